// >>> src/ift_fifo.sv
// small message fifo with valid/ready on both sides
`timescale 1ns/10ps
module ift_fifo #(
    parameter int W = 64,
    parameter int D = 4
) (
    input  wire logic clk,
    input  wire logic arst_n,
    ift_stream_if.snk in_s,
    ift_stream_if.src out_s
);
    localparam int PW = $clog2(D);
    typedef struct packed {
        logic [PW-1:0] rp;
        logic [PW-1:0] wp;
        logic [PW:0]   cnt;
    } ift_fifo_st_t;
    ift_fifo_st_t st_ff, nxt_st;
    logic [W-1:0] mem_ff [D];
    logic         do_wr, do_rd;

    // handshakes and honest full/empty
    assign in_s.ready  = (st_ff.cnt != (PW+1)'(D));
    assign out_s.valid = (st_ff.cnt != '0);
    assign out_s.data  = mem_ff[st_ff.rp];
    assign do_wr = in_s.valid && in_s.ready;
    assign do_rd = out_s.valid && out_s.ready;

    // pointer and count update
    always_comb begin
        nxt_st = st_ff;
        if (do_wr) begin
            nxt_st.wp = (st_ff.wp == PW'(D-1)) ? '0 : st_ff.wp + 1'b1;
        end
        if (do_rd) begin
            nxt_st.rp = (st_ff.rp == PW'(D-1)) ? '0 : st_ff.rp + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_ff[st_ff.wp] <= in_s.data;
        end
    end
endmodule

// >>> src/ift_pkg.sv
// constants shared by the instruction-flow tracer modules
package ift_pkg;
    // message layout
    localparam int MSG_W     = 64;
    localparam int TYPE_LSB  = 60;
    localparam int AUX_LSB   = 48;
    localparam int DELTA_LSB = 32;
    localparam int FIFO_D    = 4;
    // register word addresses
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_UTM0 = 4'h1;
    localparam logic [3:0] A_UTM1 = 4'h2;
    localparam logic [3:0] A_STAT = 4'h3;
    localparam logic [3:0] A_BIDX = 4'h4;
    localparam logic [3:0] A_BLO  = 4'h5;
    localparam logic [3:0] A_BHI  = 4'h6;
    // control bits
    localparam int C_NORM   = 0;
    localparam int C_CALL   = 1;
    localparam int C_EXC    = 2;
    localparam int C_BRK    = 3;
    localparam int C_FDATA  = 4;
    localparam int C_DELTA  = 5;
    localparam int C_ONCHIP = 6;
    localparam int C_OFFCHP = 7;
    localparam int C_BIST   = 8;
    localparam logic [15:0] CTRL_RST = 16'h00c1;
    // status bits
    localparam int S_WRAP  = 24;
    localparam int S_OVF   = 25;
    localparam int S_BDONE = 26;
    localparam int S_BFAIL = 27;
    localparam int S_LOCK  = 28;
    // message types
    localparam logic [3:0] T_PC    = 4'h1;
    localparam logic [3:0] T_CALL  = 4'h2;
    localparam logic [3:0] T_RET   = 4'h3;
    localparam logic [3:0] T_EXC   = 4'h4;
    localparam logic [3:0] T_ERET  = 4'h5;
    localparam logic [3:0] T_BRK   = 4'h6;
    localparam logic [3:0] T_FDATA = 4'h7;
    localparam logic [3:0] T_UTM0  = 4'h8;
    localparam logic [3:0] T_UTM1  = 4'h9;
    localparam int N_IBRK = 8;
    localparam int N_DBRK = 4;
    localparam logic [63:0] BIST_PAT = 64'ha5a5_5a5a_c3c3_3c3c;
    typedef enum logic [1:0] {
        B_IDLE  = 2'b00,
        B_WRITE = 2'b01,
        B_READ  = 2'b10
    } ift_bist_t;
endpackage

// >>> src/ift_stream_if.sv
// valid/ready message stream between tracer parts
`timescale 1ns/10ps
interface ift_stream_if #(parameter int W = 64);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> src/ift_tracer.sv
// instruction-flow tracer: message build, fifo, buffer, trace port
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module ift_tracer #(
    parameter bit USE_ONCHIP = 1'b1,
    parameter bit USE_OFFCHP = 1'b1,
    parameter int BUF_BYTES  = 256,
    parameter bit BIST_EN    = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic        debug_lockout_input,
    input  wire logic        probe_brk_req,
    input  wire logic        retire_valid,
    input  wire logic [31:0] retire_pc,
    input  wire logic        call_evt,
    input  wire logic        ret_evt,
    input  wire logic        exc_evt,
    input  wire logic        eret_evt,
    input  wire logic [7:0]  ibrk_hit,
    input  wire logic [3:0]  dbrk_hit,
    input  wire logic [31:0] dbrk_pc,
    input  wire logic [31:0] dacc_value,
    input  wire logic        dacc_store,
    input  wire logic [1:0]  dacc_size,
    input  wire logic [6:0]  dacc_addr_lo,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             probe_debug_interrupt,
    output logic             offchip_trace_port_valid,
    output logic      [63:0] offchip_trace_port_data,
    input  wire logic        offchip_trace_port_ready
);
    localparam int ENTRIES = BUF_BYTES / (ift_pkg::MSG_W / 8);
    localparam int AW      = $clog2(ENTRIES);
    typedef struct packed {
        logic                lock_s1;
        logic                lock_s2;
        logic                brk_s1;
        logic                brk_s2;
        logic                probe_irq;
        logic [15:0]         ctrl;
        logic                utm_pend;
        logic                utm_sel;
        logic [31:0]         utm_val;
        logic [15:0]         delta;
        logic                ovf;
        logic [AW-1:0]       wptr;
        logic                wrap;
        logic [AW-1:0]       rd_idx;
        logic [31:0]         rdata;
        logic                tp_valid;
        logic [63:0]         tp_data;
        ift_pkg::ift_bist_t  bist;
        logic [AW-1:0]       bidx;
        logic                bist_fail;
        logic                bist_done;
    } ift_state_t;

    ift_state_t    st_ff, nxt_st;
    logic [63:0]   buf_ff [ENTRIES];
    ift_stream_if #(.W(ift_pkg::MSG_W)) push_s ();
    ift_stream_if #(.W(ift_pkg::MSG_W)) pop_s ();
    logic          cand_vld, push, pop, mem_we;
    logic          onchip, offchip, bist_busy;
    logic [3:0]    cand_type, hit_id;
    logic [11:0]   cand_aux;
    logic [31:0]   cand_pay;
    logic [15:0]   cand_delta;
    logic [AW-1:0] mem_wa, next_bidx;
    logic [63:0]   mem_wd;
    // breakpoint id: bit 3 marks data, data hits take priority
    always_comb begin
        hit_id = 4'h0;
        for (int i = ift_pkg::N_IBRK - 1; i >= 0; i--) begin
            if (ibrk_hit[i]) begin
                hit_id = {1'b0, 3'(i)};
            end
        end
        for (int j = ift_pkg::N_DBRK - 1; j >= 0; j--) begin
            if (dbrk_hit[j]) begin
                hit_id = {1'b1, 3'(j)};
            end
        end
    end
    assign onchip    = USE_ONCHIP && st_ff.ctrl[ift_pkg::C_ONCHIP];
    assign offchip   = USE_OFFCHP && st_ff.ctrl[ift_pkg::C_OFFCHP];
    assign bist_busy = (st_ff.bist != ift_pkg::B_IDLE);
    // message selection, one per cycle
    always_comb begin
        cand_vld  = 1'b0;
        cand_type = ift_pkg::T_PC;
        cand_aux  = 12'h000;
        cand_pay  = 32'h0000_0000;
        if (st_ff.utm_pend) begin
            cand_vld  = 1'b1;
            cand_type = st_ff.utm_sel ? ift_pkg::T_UTM1 : ift_pkg::T_UTM0;
            cand_pay  = st_ff.utm_val;
        end else if (st_ff.ctrl[ift_pkg::C_NORM]) begin
            cand_vld = retire_valid;
            cand_pay = retire_pc;
        end else if (st_ff.ctrl[ift_pkg::C_BRK]
                     && (|ibrk_hit || |dbrk_hit)) begin
            cand_vld  = 1'b1;
            cand_type = ift_pkg::T_BRK;
            cand_aux  = {8'h00, hit_id};
            cand_pay  = hit_id[3] ? dbrk_pc : 32'h0000_0000;
        end else if (st_ff.ctrl[ift_pkg::C_FDATA] && |dbrk_hit) begin
            cand_vld  = 1'b1;
            cand_type = ift_pkg::T_FDATA;
            cand_aux  = {hit_id[1:0], dacc_store, dacc_size,
                         dacc_addr_lo};
            cand_pay  = dacc_value;
        end else if (st_ff.ctrl[ift_pkg::C_CALL] && call_evt) begin
            cand_vld  = 1'b1;
            cand_type = ift_pkg::T_CALL;
            cand_pay  = retire_pc;
        end else if (st_ff.ctrl[ift_pkg::C_CALL] && ret_evt) begin
            cand_vld  = 1'b1;
            cand_type = ift_pkg::T_RET;
            cand_pay  = retire_pc;
        end else if (st_ff.ctrl[ift_pkg::C_EXC] && exc_evt) begin
            cand_vld  = 1'b1;
            cand_type = ift_pkg::T_EXC;
            cand_pay  = retire_pc;
        end else if (st_ff.ctrl[ift_pkg::C_EXC] && eret_evt) begin
            cand_vld  = 1'b1;
            cand_type = ift_pkg::T_ERET;
            cand_pay  = retire_pc;
        end
    end
    // cycle delta goes into the message only when enabled
    assign cand_delta = st_ff.ctrl[ift_pkg::C_DELTA] ? st_ff.delta
                                                     : 16'h0000;
    // lockout suppresses every push into the trace stream
    assign push_s.valid = cand_vld && !st_ff.lock_s2
                          && (onchip || offchip) && clk_en;
    assign push_s.data  = {cand_type, cand_aux, cand_delta, cand_pay};
    assign push = push_s.valid && push_s.ready;
    // drain in order into buffer and/or trace port
    assign pop_s.ready = clk_en && !bist_busy
                         && (!offchip || !st_ff.tp_valid
                             || offchip_trace_port_ready);
    assign pop = pop_s.valid && pop_s.ready;
    ift_fifo #(
        .W (ift_pkg::MSG_W),
        .D (ift_pkg::FIFO_D)
    ) u_fifo (
        .clk    (clk),
        .arst_n (arst_n),
        .in_s   (push_s.snk),
        .out_s  (pop_s.src)
    );
    assign next_bidx = st_ff.bidx + 1'b1;
    // buffer write port: trace drain or self-test pattern
    always_comb begin
        mem_we = 1'b0;
        mem_wa = st_ff.wptr;
        mem_wd = pop_s.data;
        if (st_ff.bist == ift_pkg::B_WRITE) begin
            mem_we = clk_en;
            mem_wa = st_ff.bidx;
            mem_wd = ift_pkg::BIST_PAT ^ 64'(st_ff.bidx);
        end else if (pop && onchip) begin
            mem_we = 1'b1;
        end
    end
    // next state of every register
    always_comb begin
        nxt_st = st_ff;
        nxt_st.lock_s1 = debug_lockout_input;
        nxt_st.lock_s2 = st_ff.lock_s1;
        nxt_st.brk_s1  = probe_brk_req;
        nxt_st.brk_s2  = st_ff.brk_s1;
        // probe override ignores the lockout
        nxt_st.probe_irq = st_ff.brk_s2;
        // delta counter restarts on every stored message
        if (push) begin
            nxt_st.delta = 16'h0000;
        end else if (st_ff.delta != 16'hffff) begin
            nxt_st.delta = st_ff.delta + 16'h0001;
        end
        if (push && st_ff.utm_pend) begin
            nxt_st.utm_pend = 1'b0;
        end
        if (push_s.valid && !push_s.ready) begin
            nxt_st.ovf = 1'b1;
        end
        nxt_st.ctrl[ift_pkg::C_BIST] = 1'b0;
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                ift_pkg::A_CTRL: begin
                    nxt_st.ctrl = reg_wdata[15:0];
                    if (!BIST_EN || bist_busy) begin
                        nxt_st.ctrl[ift_pkg::C_BIST] = 1'b0;
                    end
                end
                ift_pkg::A_UTM0, ift_pkg::A_UTM1: begin
                    if (st_ff.utm_pend && !push) begin
                        nxt_st.ovf = 1'b1;
                    end
                    nxt_st.utm_pend = !st_ff.lock_s2;
                    nxt_st.utm_sel  = (reg_addr == ift_pkg::A_UTM1);
                    nxt_st.utm_val  = reg_wdata;
                end
                ift_pkg::A_STAT: begin
                    // clear overflow; a new overflow wins
                    if (reg_wdata[ift_pkg::S_OVF]
                        && !(push_s.valid && !push_s.ready)) begin
                        nxt_st.ovf = 1'b0;
                    end
                end
                ift_pkg::A_BIDX: begin
                    nxt_st.rd_idx = reg_wdata[AW-1:0];
                end
                default: begin
                end
            endcase
        end
        // buffer write pointer wraps over the whole buffer
        if (pop && onchip) begin
            nxt_st.wptr = st_ff.wptr + 1'b1;
            if (st_ff.wptr == AW'(ENTRIES - 1)) begin
                nxt_st.wrap = 1'b1;
            end
        end
        if (pop && offchip) begin
            nxt_st.tp_valid = 1'b1;
            nxt_st.tp_data  = pop_s.data;
        end else if (offchip_trace_port_ready) begin
            nxt_st.tp_valid = 1'b0;
        end
        // self-test: write pattern, read it back
        case (st_ff.bist)
            ift_pkg::B_IDLE: begin
                if (BIST_EN && st_ff.ctrl[ift_pkg::C_BIST]) begin
                    nxt_st.bist      = ift_pkg::B_WRITE;
                    nxt_st.bidx      = '0;
                    nxt_st.bist_fail = 1'b0;
                    nxt_st.bist_done = 1'b0;
                end
            end
            ift_pkg::B_WRITE: begin
                nxt_st.bidx = next_bidx;
                if (st_ff.bidx == AW'(ENTRIES - 1)) begin
                    nxt_st.bist = ift_pkg::B_READ;
                end
            end
            ift_pkg::B_READ: begin
                nxt_st.bidx = next_bidx;
                if (buf_ff[st_ff.bidx]
                    != (ift_pkg::BIST_PAT ^ 64'(st_ff.bidx))) begin
                    nxt_st.bist_fail = 1'b1;
                end
                if (st_ff.bidx == AW'(ENTRIES - 1)) begin
                    nxt_st.bist      = ift_pkg::B_IDLE;
                    nxt_st.bist_done = 1'b1;
                    nxt_st.wptr      = '0;
                    nxt_st.wrap      = 1'b0;
                end
            end
            default: begin
                nxt_st.bist = ift_pkg::B_IDLE;
            end
        endcase
        // read data stands in the cycle after the strobe only
        nxt_st.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                ift_pkg::A_CTRL: nxt_st.rdata = {16'h0000, st_ff.ctrl};
                ift_pkg::A_UTM0,
                ift_pkg::A_UTM1: nxt_st.rdata = st_ff.utm_val;
                ift_pkg::A_STAT: begin
                    nxt_st.rdata = 32'(st_ff.wptr);
                    nxt_st.rdata[ift_pkg::S_WRAP]  = st_ff.wrap;
                    nxt_st.rdata[ift_pkg::S_OVF]   = st_ff.ovf;
                    nxt_st.rdata[ift_pkg::S_BDONE] = st_ff.bist_done;
                    nxt_st.rdata[ift_pkg::S_BFAIL] = st_ff.bist_fail;
                    nxt_st.rdata[ift_pkg::S_LOCK]  = st_ff.lock_s2;
                end
                ift_pkg::A_BIDX: nxt_st.rdata = 32'(st_ff.rd_idx);
                ift_pkg::A_BLO:  nxt_st.rdata = buf_ff[st_ff.rd_idx][31:0];
                ift_pkg::A_BHI:  nxt_st.rdata = buf_ff[st_ff.rd_idx][63:32];
                default:         nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end
    // state register, frozen while the clock enable is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff      <= '0;
            st_ff.ctrl <= ift_pkg::CTRL_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end
    // trace buffer memory
    always_ff @(posedge clk) begin
        if (mem_we) begin
            buf_ff[mem_wa] <= mem_wd;
        end
    end
    assign reg_rdata                = st_ff.rdata;
    assign probe_debug_interrupt    = st_ff.probe_irq;
    assign offchip_trace_port_valid = st_ff.tp_valid;
    assign offchip_trace_port_data  = st_ff.tp_data;
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_push;
        push;
    endsequence
    sequence s_brk_pin;
        clk_en && st_ff.brk_s2 ##1 clk_en;
    endsequence
    chk_lockout_blocks: assert property (
        st_ff.lock_s2 |-> !push_s.valid)
        else $error("push while locked out");
    chk_probe_override: assert property (
        s_brk_pin |-> probe_debug_interrupt)
        else $error("probe interrupt not raised");
    chk_delta_restart: assert property (
        s_push ##1 clk_en |-> st_ff.delta == 16'h0000)
        else $error("delta not restarted");
    chk_delta_field: assert property (
        push |-> push_s.data[47:32] == (st_ff.ctrl[ift_pkg::C_DELTA]
                                        ? st_ff.delta : 16'h0000))
        else $error("wrong delta in message");
    chk_pc_only: assert property (
        push && push_s.data[63:60] == ift_pkg::T_PC
        |-> push_s.data[31:0] == retire_pc && retire_valid)
        else $error("normal message not a retired pc");
    chk_utm_first: assert property (
        push && st_ff.utm_pend && !reg_wr
        |-> push_s.data[31:0] == st_ff.utm_val ##1 !st_ff.utm_pend)
        else $error("user message not inserted");
    chk_dbrk_pc: assert property (
        push && push_s.data[63:60] == ift_pkg::T_BRK && |dbrk_hit
        |-> push_s.data[31:0] == dbrk_pc && push_s.data[51])
        else $error("data hit lacks pc");
    chk_special_gated: assert property (
        push && push_s.data[63:60] == ift_pkg::T_CALL
        |-> !st_ff.ctrl[ift_pkg::C_NORM] && call_evt)
        else $error("call traced while normal tracing");
    chk_order_store: assert property (
        pop && onchip && !bist_busy && clk_en
        |=> st_ff.wptr == $past(st_ff.wptr) + 1'b1)
        else $error("buffer pointer did not advance");
endmodule

// >>> tb/ift_probe_model.sv
// trace collector model sitting on the off-chip trace port
`timescale 1ns/10ps
module ift_probe_model (
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic        valid,
    input  wire logic [63:0] data,
    output logic             ready
);
    logic [63:0] msgs[$];
    // refuse beats while stalled, otherwise take each beat at once
    assign ready = !stall;
    // keep every accepted beat in arrival order
    always @(posedge clk) begin
        if (valid && ready) begin
            msgs.push_back(data);
        end
    end
endmodule

// >>> tb/tb.sv
// self-checking bench for the instruction-flow tracer
`timescale 1ns/10ps
module tb;
    logic        clk = 0, arst_n = 0, lock = 0, brq = 0, stall = 0;
    logic        rv = 0, wr = 0, rd = 0, dst = 0;
    logic [3:0]  evs = 0, db = 0, addr = 0;
    logic [7:0]  ib = 0;
    logic [31:0] pc = 0, dpc = 0, dval = 0, wdata = 0, rdata, rbuf;
    logic [1:0]  dsz = 0;
    logic [6:0]  dlo = 0;
    logic [63:0] tdata, last;
    logic        tvalid, tready, irq;
    int          miscompares = 0, compares = 0;

    ift_tracer u_dut (
        .clk(clk), .arst_n(arst_n), .clk_en(1'b1),
        .debug_lockout_input(lock), .probe_brk_req(brq),
        .retire_valid(rv), .retire_pc(pc), .call_evt(evs[3]),
        .ret_evt(evs[2]), .exc_evt(evs[1]), .eret_evt(evs[0]),
        .ibrk_hit(ib), .dbrk_hit(db), .dbrk_pc(dpc), .dacc_value(dval),
        .dacc_store(dst), .dacc_size(dsz), .dacc_addr_lo(dlo),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .probe_debug_interrupt(irq),
        .offchip_trace_port_valid(tvalid), .offchip_trace_port_data(tdata),
        .offchip_trace_port_ready(tready)
    );
    ift_probe_model u_probe (
        .clk(clk), .stall(stall), .valid(tvalid), .data(tdata),
        .ready(tready)
    );

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic tally_and_finish();
        if (miscompares == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle register strobes, bus master style
    task automatic reg_write(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_read(logic [3:0] a);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rbuf = rdata;
    endtask

    // one-cycle core event pulse with its qualifiers
    task automatic ev(logic r, logic [3:0] e, logic [7:0] i, logic [3:0] d,
                      logic [31:0] p);
        @(posedge clk);
        rv <= r; evs <= e; ib <= i; db <= d; pc <= p;
        @(posedge clk);
        rv <= 1'b0; evs <= 4'h0; ib <= 8'h00; db <= 4'h0;
    endtask

    // pull the next collected message, bounded wait
    task automatic get_msg();
        int n;
        for (n = 0; n < 60 && u_probe.msgs.size() == 0; n++) @(posedge clk);
        if (u_probe.msgs.size() == 0) begin
            check("message arrival", 64'h0, 64'h1);
            tally_and_finish();
        end else begin
            last = u_probe.msgs.pop_front();
        end
    endtask

    task automatic expect_msg(logic [3:0] t, logic [11:0] aux,
                              logic [31:0] pay);
        get_msg();
        check("msg type", last[63:60], t);
        check("msg aux", last[59:48], aux);
        check("msg payload", last[31:0], pay);
    endtask

    task automatic t_reset_and_map();
        reg_read(ift_pkg::A_CTRL);
        check("ctrl reset", rbuf, ift_pkg::CTRL_RST);
        reg_write(4'hf, 32'h0000_00ff);
        reg_read(4'hf);
        check("unmapped read", rbuf, 32'h0);
        reg_read(ift_pkg::A_CTRL);
        check("ctrl kept", rbuf, ift_pkg::CTRL_RST);
    endtask

    task automatic t_normal_pc();
        dval <= 32'hdead_beef;
        ev(1'b1, 4'h0, 8'h00, 4'h1, 32'h0000_1230);
        expect_msg(ift_pkg::T_PC, 12'h000, 32'h0000_1230);
        reg_write(ift_pkg::A_BIDX, 32'h0);
        reg_read(ift_pkg::A_BLO);
        check("buffer entry", rbuf, 32'h0000_1230);
    endtask

    task automatic t_user_msgs();
        reg_write(ift_pkg::A_UTM0, 32'h1357_9bdf);
        expect_msg(ift_pkg::T_UTM0, 12'h000, 32'h1357_9bdf);
        reg_write(ift_pkg::A_UTM1, 32'hfedc_ba98);
        expect_msg(ift_pkg::T_UTM1, 12'h000, 32'hfedc_ba98);
    endtask

    task automatic t_specials();
        reg_write(ift_pkg::A_CTRL, 32'h0000_00ce);
        ev(1'b1, 4'h8, 8'h00, 4'h0, 32'h0000_0100);
        expect_msg(ift_pkg::T_CALL, 12'h000, 32'h0000_0100);
        ev(1'b1, 4'h4, 8'h00, 4'h0, 32'h0000_0104);
        expect_msg(ift_pkg::T_RET, 12'h000, 32'h0000_0104);
        ev(1'b1, 4'h2, 8'h00, 4'h0, 32'h0000_0108);
        expect_msg(ift_pkg::T_EXC, 12'h000, 32'h0000_0108);
        ev(1'b1, 4'h1, 8'h00, 4'h0, 32'h0000_010c);
        expect_msg(ift_pkg::T_ERET, 12'h000, 32'h0000_010c);
        dpc <= 32'h0000_2468;
        ev(1'b0, 4'h0, 8'h00, 4'h4, 32'h0);
        expect_msg(ift_pkg::T_BRK, 12'h00a, 32'h0000_2468);
        ev(1'b0, 4'h0, 8'h80, 4'h0, 32'h0);
        expect_msg(ift_pkg::T_BRK, 12'h007, 32'h0);
        reg_write(ift_pkg::A_CTRL, 32'h0000_00d0);
        dst <= 1'b1; dsz <= 2'b10; dlo <= 7'h5a; dval <= 32'h0bad_cafe;
        ev(1'b0, 4'h0, 8'h00, 4'h8, 32'h0);
        expect_msg(ift_pkg::T_FDATA, 12'hf5a, 32'h0bad_cafe);
    endtask

    task automatic t_delta();
        reg_write(ift_pkg::A_CTRL, 32'h0000_00e1);
        ev(1'b1, 4'h0, 8'h00, 4'h0, 32'h0000_0200);
        ev(1'b1, 4'h0, 8'h00, 4'h0, 32'h0000_0204);
        repeat (7) @(posedge clk);
        ev(1'b1, 4'h0, 8'h00, 4'h0, 32'h0000_0208);
        get_msg();
        get_msg();
        check("delta short gap", last[47:32], 16'h0001);
        get_msg();
        check("delta long gap", last[47:32], 16'h0008);
    endtask

    task automatic t_lockout();
        lock <= 1'b1;
        repeat (4) @(posedge clk);
        reg_read(ift_pkg::A_STAT);
        check("lock status", rbuf[ift_pkg::S_LOCK], 1'b1);
        ev(1'b1, 4'h0, 8'h00, 4'h0, 32'h0000_0300);
        reg_write(ift_pkg::A_UTM0, 32'h0000_0001);
        brq <= 1'b1;
        repeat (20) @(posedge clk);
        check("trace silent", u_probe.msgs.size(), 64'd0);
        check("probe override", irq, 1'b1);
        brq <= 1'b0;
        lock <= 1'b0;
        repeat (5) @(posedge clk);
        check("override off", irq, 1'b0);
    endtask

    task automatic t_overflow_order();
        int i;
        logic [31:0] prev;
        stall <= 1'b1;
        for (i = 1; i <= 10; i++) ev(1'b1, 4'h0, 8'h00, 4'h0, i);
        stall <= 1'b0;
        repeat (30) @(posedge clk);
        check("some dropped", u_probe.msgs.size() < 10, 1'b1);
        prev = 0;
        while (u_probe.msgs.size() > 0) begin
            last = u_probe.msgs.pop_front();
            check("in order", last[31:0] > prev, 1'b1);
            prev = last[31:0];
        end
        reg_read(ift_pkg::A_STAT);
        check("ovf set", rbuf[ift_pkg::S_OVF], 1'b1);
        reg_write(ift_pkg::A_STAT, 32'h0200_0000);
        reg_read(ift_pkg::A_STAT);
        check("ovf clear", rbuf[ift_pkg::S_OVF], 1'b0);
    endtask

    task automatic t_self_test();
        reg_write(ift_pkg::A_CTRL, 32'h0000_01c1);
        repeat (70) @(posedge clk);
        reg_read(ift_pkg::A_STAT);
        check("bist status", rbuf, 32'h0400_0000);
        reg_write(ift_pkg::A_BIDX, 32'h0000_0001);
        reg_read(ift_pkg::A_BHI);
        check("bist high", rbuf, ift_pkg::BIST_PAT[63:32]);
        reg_read(ift_pkg::A_BLO);
        check("bist low", rbuf,
              ift_pkg::BIST_PAT[31:0] ^ 32'h0000_0001);
        reg_read(ift_pkg::A_CTRL);
        check("bist start clears", rbuf, 32'h0000_00c1);
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_and_map();
        t_normal_pc();
        t_user_msgs();
        t_specials();
        t_delta();
        t_lockout();
        reg_write(ift_pkg::A_CTRL, 32'h0000_00c1);
        t_overflow_order();
        t_self_test();
        tally_and_finish();
    end
endmodule
